//--- hw/rtcat_pkg.sv
// Shared constants and types for the RTC alarm, timer and serial register core
package rtcat_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR    = 7'h51;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] REG_CTRL1     = 4'h0;
  localparam logic [3:0] REG_CTRL2     = 4'h1;
  localparam logic [3:0] REG_SECONDS   = 4'h2;
  localparam logic [3:0] REG_MINUTES   = 4'h3;
  localparam logic [3:0] REG_HOURS     = 4'h4;
  localparam logic [3:0] REG_DAYS      = 4'h5;
  localparam logic [3:0] REG_WEEKDAYS  = 4'h6;
  localparam logic [3:0] REG_YEARS     = 4'h8;
  localparam logic [3:0] REG_MIN_ALARM = 4'h9;
  localparam logic [3:0] REG_HR_ALARM  = 4'hA;
  localparam logic [3:0] REG_DAY_ALARM = 4'hB;
  localparam logic [3:0] REG_WDY_ALARM = 4'hC;
  localparam logic [3:0] REG_SQW_CTRL  = 4'hD;
  localparam logic [3:0] REG_TMR_CTRL  = 4'hE;
  localparam logic [3:0] REG_TMR_COUNT = 4'hF;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int TEST_BIT = 7, STOP_BIT = 5, FTEST_BIT = 3;
  localparam int PULSE_SEL_BIT = 4, AF_BIT = 3, TF_BIT = 2, AIE_BIT = 1, TIE_BIT = 0;
  localparam int TOP_BIT = 7;
  localparam logic [6:0] MIN_MASK = 7'h7F, HOUR_MASK = 7'h3F, DAY_MASK = 7'h3F, WDAY_MASK = 7'h07;
  localparam logic [7:0] ALARM_RESET = 8'h80;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int OSC_HZ = 32768;
  localparam int DIV_W = 15;
  localparam int DIV_4096_BITS = 3, DIV_64_BITS = 9, DIV_1_BITS = 15;
  localparam int WAVE_1024_BIT = 4, WAVE_32_BIT = 9, WAVE_1_BIT = 14;
  localparam logic [5:0] SECS_LAST = 6'h3B;
  localparam logic [9:0] PW_8192 = 10'(OSC_HZ / 8192);
  localparam logic [9:0] PW_4096 = 10'(OSC_HZ / 4096);
  localparam logic [9:0] PW_128  = 10'(OSC_HZ / 128);
  localparam logic [9:0] PW_64   = 10'(OSC_HZ / 64);

  typedef logic [7:0] rtcat_byte_t;
  typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_1, SRC_60} rtcat_src_t;
  typedef enum logic [1:0] {SQW_32K, SQW_1024, SQW_32, SQW_1} rtcat_sqw_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_WORD, I2C_WDATA,
                            I2C_ACK_RX, I2C_RDATA, I2C_RACK} rtcat_i2c_t;

endpackage

//--- hw/rtcat_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module rtcat_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      q_out  <= '0;
    end else begin
      stage1 <= d_in;
      q_out  <= stage1;
    end
  end
endmodule

//--- hw/rtcat_timebase.sv
// Oscillator divider chain: source ticks for the timer and square-wave taps
`timescale 1ns/1ns
module rtcat_timebase
  import rtcat_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       osc_in,
  input  wire logic       stop_in,
  output logic            osc_tick_out,
  output logic [3:0]      src_tick_out,
  output logic [3:0]      wave_out
);
  logic             osc_q;
  logic [DIV_W-1:0] div;
  logic [5:0]       secs;

  function automatic logic wraps(input logic [DIV_W-1:0] d, input int n);
    logic r;
    r = 1'h1;
    for (int i = 0; i < n; i++) begin
      r = r & d[i];
    end
    return r;
  endfunction

  wire tick = osc_in & ~osc_q;

  // Stop freezes the chain at zero but leaves the raw oscillator tap alive
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_q        <= 1'h0;
      div          <= '0;
      secs         <= 6'h00;
      osc_tick_out <= 1'h0;
      src_tick_out <= 4'h0;
    end else begin
      osc_q           <= osc_in;
      osc_tick_out    <= tick;
      src_tick_out[0] <= tick & ~stop_in & wraps(div, DIV_4096_BITS);
      src_tick_out[1] <= tick & ~stop_in & wraps(div, DIV_64_BITS);
      src_tick_out[2] <= tick & ~stop_in & wraps(div, DIV_1_BITS);
      src_tick_out[3] <= tick & ~stop_in & wraps(div, DIV_1_BITS) & (secs == SECS_LAST);
      if (stop_in) begin
        div  <= '0;
        secs <= 6'h00;
      end else if (tick) begin
        div <= div + 15'h0001;
        if (wraps(div, DIV_1_BITS)) begin
          secs <= (secs == SECS_LAST) ? 6'h00 : secs + 6'h01;
        end
      end
    end
  end

  assign wave_out = {div[WAVE_1_BIT], div[WAVE_32_BIT], div[WAVE_1024_BIT], osc_q};
endmodule

//--- hw/rtcat_top.sv
// RTC support core: serial register slave, alarm, countdown timer, square wave
//
// Operation
// - Alarm interrupt enable gates alarm flag
// - Timer interrupt enable gates timer flag
// - Pulse width from source and count
// - Flag and pulse together; zero stops
// - Alarm field with top bit set excluded
// - Alarm flag sets on first full match
// - Persisting match never re-sets cleared flag
// - Source select picks countdown clock
// - Timer control bit 7 runs timer
// - Eight-bit countdown sets timer flag
// - Pulse each period; flag stays set
// - Countdown read returns live count
// - Square-wave inhibit releases open-drain pin
// - Frequency select picks square-wave rate
// - Reset clears all except listed ones
// - Supply-low sets flag, software clears it
// - Address 1010001 plus direction is acknowledged
// - Reads start at stored word pointer
// - Only low four address bits used
// - Acknowledge bytes; release after master nack
// - Pointer auto-increments over sixteen registers
// - Writing zero clears flag, one keeps
// - Level mode follows flag; alarm holds
// - Interrupt is OR of enabled sources
`timescale 1ns/1ns
module rtcat_top
  import rtcat_pkg::*;
(
  input  wire logic               clock_in,
  input  wire logic               reset_n_in,
  input  wire logic               osc_in,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  input  wire logic               supply_low_in,
  input  wire logic               cal_load_in,
  input  wire rtcat_pkg::rtcat_byte_t cal_minute_in,
  input  wire rtcat_pkg::rtcat_byte_t cal_hour_in,
  input  wire rtcat_pkg::rtcat_byte_t cal_day_in,
  input  wire rtcat_pkg::rtcat_byte_t cal_weekday_in,
  output logic                    sda_out,
  output logic                    sda_oe_n_out,
  output logic                    int_out,
  output logic                    int_oe_n_out,
  output logic                    sqw_out,
  output logic                    sqw_oe_n_out
);
  import rtcat_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rst_s1;
  logic       rst_n;
  logic [3:0] pin_s;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1 <= 1'h0;
      rst_n  <= 1'h0;
    end else begin
      rst_s1 <= 1'h1;
      rst_n  <= rst_s1;
    end
  end

  rtcat_sync #(.W(4)) u_pin_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n),
    .d_in     ({osc_in, scl_in, sda_in, supply_low_in}),
    .q_out    (pin_s)
  );

  wire osc_s = pin_s[3];
  wire scl_s = pin_s[2];
  wire sda_s = pin_s[1];
  wire low_s = pin_s[0];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        test_mode, stop_chain, factory_test_alt;
  logic        irq_pulse_select, alarm_flag, timer_flag, alarm_irq_enable, timer_irq_enable;
  logic        supply_low_flag;
  logic [7:0]  time_reg [REG_SECONDS:REG_YEARS];
  logic [7:0]  alarm_reg [REG_MIN_ALARM:REG_WDY_ALARM];
  logic        square_wave_inhibit;
  rtcat_sqw_t  square_freq_sel;
  logic        timer_run;
  rtcat_src_t  timer_source_sel;
  logic [7:0]  timer_count, timer_reload;
  logic [9:0]  pulse_left;
  logic        match_q;
  logic        osc_tick;
  logic [3:0]  src_tick, wave;

  rtcat_timebase u_timebase (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n),
    .osc_in       (osc_s),
    .stop_in      (stop_chain),
    .osc_tick_out (osc_tick),
    .src_tick_out (src_tick),
    .wave_out     (wave)
  );

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  rtcat_i2c_t  state;
  logic        scl_q, sda_q, rw, ack_ok;
  logic [3:0]  bit_cnt, ptr, wr_addr;
  logic [7:0]  shreg, tx, wr_data, rd_data;
  logic        wr_stb;

  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire i2c_start = scl_s & scl_q & sda_q & ~sda_s;
  wire i2c_stop  = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_done = (bit_cnt == BYTE_BITS);

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= I2C_IDLE;
      {scl_q, sda_q, rw, ack_ok, wr_stb} <= 5'h00;
      {bit_cnt, ptr, wr_addr} <= 12'h000;
      {shreg, tx, wr_data} <= 24'h00_0000;
      sda_oe_n_out <= 1'h1;
    end else begin
      scl_q  <= scl_s;
      sda_q  <= sda_s;
      wr_stb <= 1'h0;
      if (i2c_start) begin
        state        <= I2C_ADDR;
        bit_cnt      <= 4'h0;
        sda_oe_n_out <= 1'h1;
      end else if (i2c_stop) begin
        state        <= I2C_IDLE;
        sda_oe_n_out <= 1'h1;
      end else if (scl_rise) begin
        case (state)
          I2C_ADDR, I2C_WORD, I2C_WDATA: begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          I2C_RDATA: bit_cnt <= bit_cnt + 4'h1;
          I2C_RACK:  ack_ok <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          I2C_ADDR: if (byte_done) begin
            if (shreg[7:1] == SLAVE_ADDR) begin
              rw           <= shreg[0];
              sda_oe_n_out <= 1'h0;
              state        <= I2C_ACK_ADDR;
            end else begin
              state <= I2C_IDLE;
            end
          end
          I2C_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              sda_oe_n_out <= rd_data[7];
              tx           <= {rd_data[6:0], 1'h0};
              state        <= I2C_RDATA;
            end else begin
              sda_oe_n_out <= 1'h1;
              state        <= I2C_WORD;
            end
          end
          I2C_WORD: if (byte_done) begin
            ptr          <= shreg[3:0];
            sda_oe_n_out <= 1'h0;
            state        <= I2C_ACK_RX;
          end
          I2C_WDATA: if (byte_done) begin
            wr_stb       <= 1'h1;
            wr_addr      <= ptr;
            wr_data      <= shreg;
            ptr          <= ptr + 4'h1;
            sda_oe_n_out <= 1'h0;
            state        <= I2C_ACK_RX;
          end
          I2C_ACK_RX: begin
            sda_oe_n_out <= 1'h1;
            bit_cnt      <= 4'h0;
            state        <= I2C_WDATA;
          end
          I2C_RDATA: if (byte_done) begin
            sda_oe_n_out <= 1'h1;
            ptr          <= ptr + 4'h1;
            state        <= I2C_RACK;
          end else begin
            sda_oe_n_out <= tx[7];
            tx           <= {tx[6:0], 1'h0};
          end
          I2C_RACK: if (ack_ok) begin
            sda_oe_n_out <= rd_data[7];
            tx           <= {rd_data[6:0], 1'h0};
            bit_cnt      <= 4'h0;
            state        <= I2C_RDATA;
          end else begin
            state <= I2C_IDLE;
          end
          default: state <= I2C_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and write decode
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input logic stb, input logic [3:0] a, input logic [3:0] target);
    return stb && (a == target);
  endfunction

  function automatic logic field_hit(input logic [7:0] alarm, input logic [7:0] now, input logic [6:0] mask);
    return alarm[TOP_BIT] | ((alarm[6:0] & mask) == (now[6:0] & mask));
  endfunction

  wire wr_ctrl2 = wr_hit(wr_stb, wr_addr, REG_CTRL2);
  wire wr_secs  = wr_hit(wr_stb, wr_addr, REG_SECONDS);
  wire wr_count = wr_hit(wr_stb, wr_addr, REG_TMR_COUNT);
  wire wr_time  = wr_stb && (wr_addr >= REG_SECONDS) && (wr_addr <= REG_YEARS);
  wire wr_alarm = wr_stb && (wr_addr >= REG_MIN_ALARM) && (wr_addr <= REG_WDY_ALARM);

  always_comb begin
    rd_data = ZERO_BYTE;
    case (ptr)
      REG_CTRL1:     rd_data = {test_mode, 1'h0, stop_chain, 1'h0, factory_test_alt, 3'h0};
      REG_CTRL2:     rd_data = {3'h0, irq_pulse_select, alarm_flag, timer_flag, alarm_irq_enable, timer_irq_enable};
      REG_SECONDS:   rd_data = {supply_low_flag, time_reg[REG_SECONDS][6:0]};
      REG_SQW_CTRL:  rd_data = {square_wave_inhibit, 5'h00, square_freq_sel};
      REG_TMR_CTRL:  rd_data = {timer_run, 5'h00, timer_source_sel};
      REG_TMR_COUNT: rd_data = timer_count;
      default: begin
        if (ptr <= REG_YEARS) begin
          rd_data = time_reg[ptr];
        end else begin
          rd_data = alarm_reg[ptr];
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      {test_mode, stop_chain, factory_test_alt} <= 3'h1;
      {irq_pulse_select, alarm_irq_enable, timer_irq_enable} <= 3'h0;
      {square_wave_inhibit, square_freq_sel} <= {1'h1, SQW_32K};
      {timer_run, timer_source_sel} <= {1'h0, SRC_60};
      for (int i = REG_SECONDS; i <= REG_YEARS; i++) time_reg[i] <= ZERO_BYTE;
      for (int i = REG_MIN_ALARM; i <= REG_WDY_ALARM; i++) alarm_reg[i] <= ALARM_RESET;
    end else begin
      if (wr_hit(wr_stb, wr_addr, REG_CTRL1)) begin
        test_mode        <= wr_data[TEST_BIT];
        stop_chain       <= wr_data[STOP_BIT];
        factory_test_alt <= wr_data[FTEST_BIT];
      end
      if (wr_ctrl2) begin
        irq_pulse_select <= wr_data[PULSE_SEL_BIT];
        alarm_irq_enable <= wr_data[AIE_BIT];
        timer_irq_enable <= wr_data[TIE_BIT];
      end
      if (wr_time) time_reg[wr_addr] <= wr_data;
      if (cal_load_in) begin
        time_reg[REG_MINUTES]  <= cal_minute_in;
        time_reg[REG_HOURS]    <= cal_hour_in;
        time_reg[REG_DAYS]     <= cal_day_in;
        time_reg[REG_WEEKDAYS] <= cal_weekday_in;
      end
      if (wr_alarm) alarm_reg[wr_addr] <= wr_data;
      if (wr_hit(wr_stb, wr_addr, REG_SQW_CTRL)) begin
        square_wave_inhibit <= wr_data[TOP_BIT];
        square_freq_sel     <= rtcat_sqw_t'(wr_data[1:0]);
      end
      if (wr_hit(wr_stb, wr_addr, REG_TMR_CTRL)) begin
        timer_run        <= wr_data[TOP_BIT];
        timer_source_sel <= rtcat_src_t'(wr_data[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm and supply-low flags
  // ----------------------------------------------------------------
  // Disabled fields ignored
  wire any_enabled = ~(alarm_reg[REG_MIN_ALARM][TOP_BIT] & alarm_reg[REG_HR_ALARM][TOP_BIT] &
                       alarm_reg[REG_DAY_ALARM][TOP_BIT] & alarm_reg[REG_WDY_ALARM][TOP_BIT]);
  wire all_match = any_enabled &
                   field_hit(alarm_reg[REG_MIN_ALARM], time_reg[REG_MINUTES], MIN_MASK) &
                   field_hit(alarm_reg[REG_HR_ALARM], time_reg[REG_HOURS], HOUR_MASK) &
                   field_hit(alarm_reg[REG_DAY_ALARM], time_reg[REG_DAYS], DAY_MASK) &
                   field_hit(alarm_reg[REG_WDY_ALARM], time_reg[REG_WEEKDAYS], WDAY_MASK);
  wire alarm_set = all_match & ~match_q;

  // Set beats a same-cycle software clear on every flag
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      match_q         <= 1'h0;
      alarm_flag      <= 1'h0;
      supply_low_flag <= 1'h1;
    end else begin
      match_q <= all_match;
      alarm_flag <= alarm_set | (alarm_flag & ~(wr_ctrl2 & ~wr_data[AF_BIT]));
      supply_low_flag <= low_s | (wr_secs ? wr_data[TOP_BIT] : supply_low_flag);
    end
  end

  // ----------------------------------------------------------------
  // Countdown timer
  // ----------------------------------------------------------------
  function automatic logic [9:0] pulse_width(input rtcat_src_t src, input logic count_one);
    case (src)
      SRC_4096: return count_one ? PW_8192 : PW_4096;
      SRC_64:   return count_one ? PW_128 : PW_64;
      default:  return PW_64;
    endcase
  endfunction

  wire src_tick_sel = src_tick[timer_source_sel];
  wire timer_step   = timer_run & (timer_reload != ZERO_BYTE) & src_tick_sel;
  wire timer_end    = timer_step & (timer_count <= 8'h01);

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_count  <= ZERO_BYTE;
      timer_reload <= ZERO_BYTE;
      timer_flag   <= 1'h0;
      pulse_left   <= 10'h000;
    end else begin
      if (wr_count) begin
        timer_count  <= wr_data;
        timer_reload <= wr_data;
      end else if (timer_end) begin
        timer_count <= timer_reload;
      end else if (timer_step) begin
        timer_count <= timer_count - 8'h01;
      end
      timer_flag <= timer_end | (timer_flag & ~(wr_ctrl2 & ~wr_data[TF_BIT]));
      if (timer_end) begin
        pulse_left <= pulse_width(timer_source_sel, timer_reload == 8'h01);
      end else if (osc_tick && pulse_left != 10'h000) begin
        pulse_left <= pulse_left - 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pins
  // ----------------------------------------------------------------
  // Interrupt sources
  wire timer_irq = timer_irq_enable & (irq_pulse_select ? (pulse_left != 10'h000) : timer_flag);
  wire irq_now   = (alarm_flag & alarm_irq_enable) | timer_irq;
  wire wave_sel  = wave[square_freq_sel];

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      {sda_out, int_out, sqw_out} <= 3'h0;
      int_oe_n_out <= 1'h1;
      sqw_oe_n_out <= 1'h1;
    end else begin
      int_oe_n_out <= ~irq_now;
      sqw_oe_n_out <= square_wave_inhibit | wave_sel;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  sequence s_timer_end;
    timer_end && !wr_count;
  endsequence
  sequence s_mid_step;
    timer_step && timer_count > 8'h01 && !wr_count;
  endsequence

  property p_alarm_irq;
    alarm_flag && alarm_irq_enable |=> !int_oe_n_out;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("Enabled alarm flag did not drive interrupt");
  property p_irq_quiet;
    !alarm_irq_enable && !timer_irq_enable |=> int_oe_n_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("Interrupt driven with both sources disabled");
  property p_end_flag_pulse;
    s_timer_end |=> timer_flag && pulse_left != 10'h000 && timer_count == $past(timer_reload);
  endproperty
  a_end_flag_pulse: assert property (p_end_flag_pulse) else $error("Countdown end missed flag, pulse or reload");
  property p_zero_stops;
    timer_reload == ZERO_BYTE && !wr_count |=> $stable(timer_count) && !$rose(timer_flag);
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("Timer moved with zero load");
  property p_step;
    s_mid_step |=> timer_count == $past(timer_count) - 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("Countdown did not decrement by one");
  property p_halted;
    !timer_run && !wr_count |=> $stable(timer_count);
  endproperty
  a_halted: assert property (p_halted) else $error("Stopped timer changed count");
  property p_alarm_set;
    all_match && !match_q |=> alarm_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("New alarm match did not set flag");
  property p_alarm_persist;
    !alarm_flag && match_q |=> !alarm_flag;
  endproperty
  a_alarm_persist: assert property (p_alarm_persist) else $error("Persisting match set flag again");
  property p_sqw_off;
    square_wave_inhibit [*2] |=> sqw_oe_n_out;
  endproperty
  a_sqw_off: assert property (p_sqw_off) else $error("Inhibited square wave pulled low");
  property p_ptr_step;
    wr_stb |-> ptr == wr_addr + 4'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("Pointer did not advance after write");
endmodule

//--- tb/rtcat_bus_master.sv
// Serial bus master model for the RTC core
`timescale 1ns/1ns
module rtcat_bus_master (
  input  wire logic clock_in,
  input  wire logic line_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Ten clocks a half period keeps the core's sampling margin
  task automatic half();
    repeat (10) @(posedge clock_in);
  endtask
  task automatic start();
    half();
    sda_out <= 1'b1;
    half();
    scl_out <= 1'b1;
    half();
    sda_out <= 1'b0;
    half();
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    half();
    sda_out <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    sda_out <= 1'b1;
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      half();
      sda_out <= d[i];
      half();
      scl_out <= 1'b1;
      half();
      q[i] = line_in;
      scl_out <= 1'b0;
    end
  endtask
endmodule

//--- tb/rtcat_top_tb.sv
// Self-checking bench for the RTC core
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %h got %h", n, e, g); end end
module rtcat_top_tb;
  import rtcat_pkg::*;
  logic        clock_in = 1'b0, reset_n_in = 1'b0, osc_in = 1'b0, cal_load_in = 1'b0, supply_low_in = 1'b0;
  rtcat_byte_t cal_minute_in = 8'h00;
  logic        scl, sda_m, sda_out, sda_oe_n_out, int_out, int_oe_n_out, sqw_out, sqw_oe_n_out;
  logic [8:0]  q;
  rtcat_byte_t dflt [6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03};
  int          n_mismatch = 0, checked = 0;
  int          n_low;
  initial forever #5 clock_in = ~clock_in;
  initial begin
    #3;
    forever #40 osc_in = ~osc_in;
  end
  rtcat_bus_master u_mst (.clock_in(clock_in), .line_in(sda_m & sda_oe_n_out), .scl_out(scl), .sda_out(sda_m));
  rtcat_top u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .osc_in(osc_in), .scl_in(scl),
    .sda_in(sda_m & sda_oe_n_out), .supply_low_in(supply_low_in), .cal_load_in(cal_load_in),
    .cal_minute_in(cal_minute_in), .cal_hour_in(8'h00), .cal_day_in(8'h00), .cal_weekday_in(8'h00),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .int_out(int_out), .int_oe_n_out(int_oe_n_out),
    .sqw_out(sqw_out), .sqw_oe_n_out(sqw_oe_n_out));
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input rtcat_byte_t d);
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b01}, q);
    u_mst.xfer({a, 1'b1}, q);
    u_mst.xfer({d, 1'b1}, q);
    `CHK("wr_ack", 1'b0, q[0])
    u_mst.stop();
  endtask
  task automatic rd(input logic [7:0] a, input rtcat_byte_t e);
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b01}, q);
    u_mst.xfer({a, 1'b1}, q);
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b11}, q);
    u_mst.xfer(9'h1FF, q);
    `CHK("rd_data", e, q[8:1])
    u_mst.stop();
  endtask
  task automatic cal(input rtcat_byte_t m);
    @(posedge clock_in);
    cal_minute_in <= m;
    cal_load_in <= 1'b1;
    @(posedge clock_in);
    cal_load_in <= 1'b0;
  endtask
  task automatic chk_int(input logic v);
    for (int i = 0; i < 3000 && int_oe_n_out !== v; i++) @(posedge clock_in);
    `CHK("int_oe_n", v, int_oe_n_out)
  endtask
  // Length of one whole low phase of an open-drain pin, after a high phase
  task automatic low_len(input logic use_int, output int n);
    n = 0;
    for (int i = 0; i < 300 && (use_int ? int_oe_n_out : sqw_oe_n_out) !== 1'b1; i++) @(posedge clock_in);
    for (int i = 0; i < 300 && (use_int ? int_oe_n_out : sqw_oe_n_out) !== 1'b0; i++) @(posedge clock_in);
    while (n < 300 && (use_int ? int_oe_n_out : sqw_oe_n_out) === 1'b0) begin
      n++;
      @(posedge clock_in);
    end
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b01}, q);
    u_mst.xfer(9'h013, q);
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b11}, q);
    foreach (dflt[i]) begin
      u_mst.xfer({8'hFF, i == 5}, q);
      `CHK("dflt", dflt[i], q[8:1])
    end
    u_mst.stop();
    `CHK("sda_free", 1'b1, sda_oe_n_out)
    `CHK("sqw_off", 1'b1, sqw_oe_n_out)
    u_mst.start();
    u_mst.xfer({7'h52, 2'b01}, q);
    `CHK("foreign", 1'b1, q[0])
    u_mst.stop();
    wr(8'h3D, 8'h01);
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b01}, q);
    u_mst.xfer(9'h1FB, q);
    u_mst.stop();
    u_mst.start();
    u_mst.xfer({SLAVE_ADDR, 2'b11}, q);
    u_mst.xfer(9'h1FF, q);
    `CHK("ptr", 8'h01, q[8:1])
    u_mst.stop();
    // 1024 Hz: half period is 16 oscillator periods of 8 clocks each
    low_len(1'b0, n_low);
    `CHK("sqw_half", 32'h0000_0080, n_low)
    // Stop freezes the divider at zero, so the 1024 Hz tap holds low
    wr(8'h00, 8'h20);
    `CHK("sqw_stop", 1'b0, sqw_oe_n_out)
    wr(8'h00, 8'h00);
    cal(8'h14);
    wr(8'h09, 8'h15);
    wr(8'h01, 8'h02);
    cal(8'h15);
    chk_int(1'b0);
    rd(8'h01, 8'h0A);
    wr(8'h01, 8'h02);
    cal(8'h15);
    rd(8'h01, 8'h02);
    chk_int(1'b1);
    wr(8'h0F, 8'h02);
    wr(8'h01, 8'h01);
    wr(8'h0E, 8'h80);
    chk_int(1'b0);
    rd(8'h01, 8'h05);
    // Pulsed mode, load 2 at 4096 Hz: pulse is 8 oscillator periods
    wr(8'h01, 8'h11);
    low_len(1'b1, n_low);
    `CHK("pulse_len", 32'h0000_0040, n_low)
    // Slowest source while idle
    wr(8'h0E, 8'h03);
    wr(8'h01, 8'h09);
    rd(8'h01, 8'h01);
    chk_int(1'b1);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00);
    @(posedge clock_in) supply_low_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    supply_low_in <= 1'b0;
    rd(8'h02, 8'h80);
    `CHK("pin_data", 3'h0, {sda_out, int_out, sqw_out})
    summarize();
  end
endmodule
